// file: nv_access_ctrl.v
// data nonvolatile access controller: address, data and control registers
// assumes a cpu-side byte port with sector select, same clock, and an
// interrupt controller outside that reads the flags and enables here
`timescale 1ns/1ps
`include "nv_access_defines.vh"

module data_eeprom_access_ctrl (
	// clock and reset
	input wire clock,
	input wire rst,
	input wire clockEnable,
	// cpu register port
	input wire [7:0] regSector,
	input wire [7:0] regOffset,
	input wire regWrite,
	input wire [7:0] regWdata,
	output reg [7:0] regRdata,
	// internal write-timer oscillator
	input wire oscTick,
	// interrupt hooks
	input wire globalIrqEnable,
	input wire nvIrqEnable,
	input wire mfIrqEnable,
	input wire stackFull,
	input wire nvIrqFlagClear,
	input wire mfServiced,
	output reg nvIrqFlag_q,
	output reg mfIrqFlag_q,
	output wire irqVector,
	// status
	output wire busy
);

////////////////////////////////////////////////////////////////////////
// state

localparam ST_IDLE = 4'b0001;
localparam ST_READ = 4'b0010;
localparam ST_RLOAD = 4'b0100;
localparam ST_WRITE = 4'b1000;

reg [3:0] state_q;
reg [7:0] nvAddress_q;
reg [7:0] nvData_q;
reg writePermit_q;
reg writeStart_q;
reg readPermit_q;
reg readStart_q;

wire [7:0] arrayData;
wire writeDone;

// sector-qualified decode, used for both reads and writes
function hit;
	input [7:0] sector;
	input [7:0] offset;
	input [7:0] wantSector;
	input [7:0] wantOffset;
	begin
		hit = (sector == wantSector) && (offset == wantOffset);
	end
endfunction

wire selAddr = hit(regSector, regOffset, `NV_SECTOR_LOW, `NV_ADDRESS_OFS);
wire selData = hit(regSector, regOffset, `NV_SECTOR_LOW, `NV_DATA_OFS);
wire selCtrl = hit(regSector, regOffset, `NV_SECTOR_HIGH, `NV_CONTROL_OFS);

wire ctrlWr = regWrite & selCtrl;
wire idle = (state_q == ST_IDLE);

// starts see the permit stored before this write, so setting both at once fails
wire goWrite = ctrlWr & idle & regWdata[`NV_WRITE_START_BIT] & writePermit_q;
wire goRead = ctrlWr & idle & regWdata[`NV_READ_START_BIT] & readPermit_q
	& ~goWrite;

assign busy = ~idle;

////////////////////////////////////////////////////////////////////////
// sub-blocks

nv_write_timer timer (
	.clock(clock),
	.rst(rst),
	.clockEnable(clockEnable),
	.oscTick(oscTick),
	.start(goWrite),
	.done(writeDone)
);

nv_array array (
	.clock(clock),
	.clockEnable(clockEnable),
	.addr(nvAddress_q),
	.writeEn(writeDone),
	.writeData(nvData_q),
	.readEn(state_q == ST_READ),
	.readData(arrayData)
);

////////////////////////////////////////////////////////////////////////
// address and data registers

always @(posedge clock) begin
	if (rst) begin
		nvAddress_q <= `NV_ADDRESS_RST;
		nvData_q <= `NV_DATA_RST;
	end else if (clockEnable) begin
		if (regWrite && selAddr) begin
			nvAddress_q <= regWdata;
		end
		if (state_q == ST_RLOAD) begin
			nvData_q <= arrayData;
		end else if (regWrite && selData) begin
			nvData_q <= regWdata;
		end
	end
end

////////////////////////////////////////////////////////////////////////
// control register and cycle sequencer

always @(posedge clock) begin
	if (rst) begin
		state_q <= ST_IDLE;
		writePermit_q <= 1'b0;
		writeStart_q <= 1'b0;
		readPermit_q <= 1'b0;
		readStart_q <= 1'b0;
	end else if (clockEnable) begin
		// permits follow software at any time
		if (ctrlWr) begin
			writePermit_q <= regWdata[`NV_WRITE_PERMIT_BIT];
			readPermit_q <= regWdata[`NV_READ_PERMIT_BIT];
		end
		case (state_q)
			ST_IDLE: begin
				if (goWrite) begin
					writeStart_q <= 1'b1;
					state_q <= ST_WRITE;
				end else if (goRead) begin
					readStart_q <= 1'b1;
					state_q <= ST_READ;
				end
			end
			ST_READ: begin
				state_q <= ST_RLOAD;
			end
			ST_RLOAD: begin
				// data lands this edge, so start clears together with it
				readStart_q <= 1'b0;
				state_q <= ST_IDLE;
			end
			ST_WRITE: begin
				// start writes while busy are dropped
				if (writeDone) begin
					writeStart_q <= 1'b0;
					state_q <= ST_IDLE;
				end
			end
			default: begin
				state_q <= ST_IDLE;
			end
		endcase
	end
end

////////////////////////////////////////////////////////////////////////
// interrupt request flags; a new completion beats a clear

always @(posedge clock) begin
	if (rst) begin
		nvIrqFlag_q <= 1'b0;
		mfIrqFlag_q <= 1'b0;
	end else if (clockEnable) begin
		if (writeDone) begin
			nvIrqFlag_q <= 1'b1;
		end else if (nvIrqFlagClear) begin
			nvIrqFlag_q <= 1'b0;
		end
		if (writeDone) begin
			mfIrqFlag_q <= 1'b1;
		end else if (mfServiced) begin
			mfIrqFlag_q <= 1'b0;
		end
	end
end

// vector request gated by all enables and stack room
assign irqVector = mfIrqFlag_q & nvIrqFlag_q & nvIrqEnable & mfIrqEnable
	& globalIrqEnable & ~stackFull;

////////////////////////////////////////////////////////////////////////
// read-back mux, registered

always @(posedge clock) begin
	if (rst) begin
		regRdata <= 8'h00;
	end else if (clockEnable) begin
		if (selAddr) begin
			regRdata <= nvAddress_q;
		end else if (selData) begin
			regRdata <= nvData_q;
		end else if (selCtrl) begin
			regRdata <= {4'h0, writePermit_q, writeStart_q,
				readPermit_q, readStart_q};
		end else begin
			regRdata <= 8'h00;
		end
	end
end

endmodule

// file: nv_access_defines.vh
// constants for the data nonvolatile access controller
// assumes inclusion by plain name from the design files
`ifndef NV_ACCESS_DEFINES_VH
`define NV_ACCESS_DEFINES_VH

// register placement: sector and offset within sector
`define NV_SECTOR_LOW 8'h00
`define NV_SECTOR_HIGH 8'h01
`define NV_ADDRESS_OFS 8'h00
`define NV_DATA_OFS 8'h01
`define NV_CONTROL_OFS 8'h40

// control field positions
`define NV_READ_START_BIT 0
`define NV_READ_PERMIT_BIT 1
`define NV_WRITE_START_BIT 2
`define NV_WRITE_PERMIT_BIT 3

// reset values
`define NV_ADDRESS_RST 8'h00
`define NV_DATA_RST 8'h00
`define NV_CONTROL_RST 4'h0

// array geometry
`define NV_DEPTH 256
`define NV_AWIDTH 8
`define NV_DWIDTH 8

// write timer: internal oscillator ticks per write
`define NV_WRITE_TICKS 16'h0400

`endif

// file: nv_array.v
// storage array of the nonvolatile data memory, one byte per access
// assumes one clock, write and read strobes never together
`timescale 1ns/1ps
`include "nv_access_defines.vh"

module nv_array (
	// clock
	input wire clock,
	input wire clockEnable,
	// access
	input wire [7:0] addr,
	input wire writeEn,
	input wire [7:0] writeData,
	input wire readEn,
	output reg [7:0] readData
);

reg [7:0] mem [0:`NV_DEPTH-1];

////////////////////////////////////////////////////////////////////////
// one byte per cycle; read data registered
always @(posedge clock) begin
	if (clockEnable) begin
		if (writeEn) begin
			mem[addr] <= writeData;
		end
		if (readEn) begin
			readData <= mem[addr];
		end
	end
end

endmodule

// file: nv_write_timer.v
// write duration timer on an internal oscillator tick
// assumes oscTick comes from an unrelated clock and is synchronised here
`timescale 1ns/1ps
`include "nv_access_defines.vh"

module nv_write_timer (
	// clock and reset
	input wire clock,
	input wire rst,
	input wire clockEnable,
	// internal oscillator level, free running
	input wire oscTick,
	// control
	input wire start,
	output wire done
);

reg syncA_q;
reg syncB_q;
reg syncC_q;
reg running_q;
reg [15:0] count_q;

////////////////////////////////////////////////////////////////////////
// two-stage synchroniser, third stage only for edge detection
always @(posedge clock) begin
	if (rst) begin
		syncA_q <= 1'b0;
		syncB_q <= 1'b0;
		syncC_q <= 1'b0;
	end else if (clockEnable) begin
		syncA_q <= oscTick;
		syncB_q <= syncA_q;
		syncC_q <= syncB_q;
	end
end

wire tickEdge = syncB_q & ~syncC_q;

// count oscillator edges, so length in system clocks floats
always @(posedge clock) begin
	if (rst) begin
		running_q <= 1'b0;
		count_q <= 16'h0000;
	end else if (clockEnable) begin
		if (start) begin
			running_q <= 1'b1;
			count_q <= `NV_WRITE_TICKS;
		end else if (running_q && tickEdge) begin
			count_q <= count_q - 16'h0001;
			if (count_q == 16'h0001) begin
				running_q <= 1'b0;
			end
		end
	end
end

// one-cycle pulse at the last tick
assign done = running_q & tickEdge & (count_q == 16'h0001);

endmodule

// file: nv_osc_model.sv
// free running oscillator for the write timer
// assumes nothing of the system clock
`timescale 1ns/1ps
module nv_osc_model #(
	parameter real HALF = 10.3
) (
	// oscillator level
	output reg oscTick
);
	// odd half period keeps edges drifting against the system clock
	initial begin
		oscTick = 1'b0;
		#1.3;
		forever #HALF oscTick = ~oscTick;
	end
endmodule

// file: nv_ctrl_assertions.sv
// port assertions for the nonvolatile access controller
// assumes a bind onto the controller top
`timescale 1ns/1ps
module nv_ctrl_assertions (
	// cpu side
	input wire clock,
	input wire rst,
	input wire clockEnable,
	input wire [7:0] regSector,
	input wire [7:0] regOffset,
	input wire regWrite,
	input wire [7:0] regWdata,
	input wire [7:0] regRdata,
	// interrupt side
	input wire globalIrqEnable,
	input wire nvIrqEnable,
	input wire mfIrqEnable,
	input wire stackFull,
	input wire nvIrqFlagClear,
	input wire mfServiced,
	input wire nvIrqFlag_q,
	input wire mfIrqFlag_q,
	input wire irqVector,
	input wire busy
);
	reg rdOk_q;
	reg wrOk_q;
	wire ctrlHit = clockEnable && regSector == 8'h01 && regOffset == 8'h40;
	wire ctrlWr = ctrlHit && regWrite && !busy;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////
	// permits as last stored, since a start looks at the old value
	always @(posedge clock) begin
		if (rst) begin
			rdOk_q <= 1'b0;
			wrOk_q <= 1'b0;
		end else if (ctrlHit && regWrite) begin
			rdOk_q <= regWdata[1];
			wrOk_q <= regWdata[3];
		end
	end
	chk_ctrl_upper: assert property (ctrlHit |=> regRdata[7:4] == 4'h0)
		else $error("control upper bits set");
	chk_ctrl_sector: assert property (clockEnable && regSector == 8'h00 && regOffset == 8'h40
		|=> regRdata == 8'h00)
		else $error("control seen in sector zero");
	chk_write_refused: assert property (ctrlWr && regWdata[2] && !regWdata[0] && !wrOk_q
		|=> !busy)
		else $error("write started without permit");
	chk_read_refused: assert property (ctrlWr && regWdata[0] && !regWdata[2] && !rdOk_q
		|=> !busy)
		else $error("read started without permit");
	chk_read_runs: assert property (ctrlWr && regWdata[0] && !regWdata[2] && rdOk_q
		|=> busy ##[1:4] !busy)
		else $error("read cycle not run");
	chk_flags_pair: assert property ($rose(nvIrqFlag_q) |-> mfIrqFlag_q)
		else $error("flags not set together");
	chk_nv_sticky: assert property (nvIrqFlag_q && !nvIrqFlagClear && clockEnable
		|=> nvIrqFlag_q)
		else $error("nv flag lost");
	chk_mf_service: assert property (mfServiced && clockEnable && !busy && !$fell(busy)
		|=> !mfIrqFlag_q)
		else $error("mf flag not cleared");
	chk_vector_terms: assert property (irqVector == (nvIrqFlag_q && mfIrqFlag_q
		&& globalIrqEnable && nvIrqEnable && mfIrqEnable && !stackFull))
		else $error("vector mismatch");
	// main scenarios reached
	cover property ($rose(nvIrqFlag_q));
	cover property (ctrlWr && regWdata[0]);
	cover property (irqVector);
endmodule

// file: data_eeprom_access_ctrl_tb.sv
// self-checking bench for the nonvolatile access controller
// assumes the oscillator model drives the write timer
`timescale 1ns/1ps
module data_eeprom_access_ctrl_tb;
	reg clock = 1'b0, rst = 1'b1, clockEnable = 1'b1, regWrite = 1'b0;
	reg globalIrqEnable = 1'b1, nvIrqEnable = 1'b1, mfIrqEnable = 1'b1;
	reg stackFull = 1'b0, nvIrqFlagClear = 1'b0, mfServiced = 1'b0;
	reg [7:0] regSector = 8'h00, regOffset = 8'h00, regWdata = 8'h00;
	wire [7:0] regRdata;
	wire oscTick, nvIrqFlag_q, mfIrqFlag_q, irqVector, busy;
	integer err_count = 0, cmp_count = 0;
	nv_osc_model osc_u (.oscTick(oscTick));
	data_eeprom_access_ctrl dut_u (
		.clock(clock),
		.rst(rst),
		.clockEnable(clockEnable),
		.regSector(regSector),
		.regOffset(regOffset),
		.regWrite(regWrite),
		.regWdata(regWdata),
		.regRdata(regRdata),
		.oscTick(oscTick),
		.globalIrqEnable(globalIrqEnable),
		.nvIrqEnable(nvIrqEnable),
		.mfIrqEnable(mfIrqEnable),
		.stackFull(stackFull),
		.nvIrqFlagClear(nvIrqFlagClear),
		.mfServiced(mfServiced),
		.nvIrqFlag_q(nvIrqFlag_q),
		.mfIrqFlag_q(mfIrqFlag_q),
		.irqVector(irqVector),
		.busy(busy)
	);
	////////////////////////////////////////////////
	// clock at 4 ns
	initial begin
		forever #2 clock = ~clock;
	end
	task print_verdict;
		begin
			$display("errors %0d compares %0d", err_count, cmp_count);
			if (err_count == 0 && cmp_count > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	task chk(input [7:0] got, input [7:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	// one-cycle strobe, so two writes never share an edge
	task wr(input [7:0] sec, input [7:0] ofs, input [7:0] dat);
		begin
			@(posedge clock);
			regSector <= sec;
			regOffset <= ofs;
			regWdata <= dat;
			regWrite <= 1'b1;
			@(posedge clock);
			regWrite <= 1'b0;
		end
	endtask
	// read data is registered, so look one edge later
	task rd(input [7:0] sec, input [7:0] ofs, input [7:0] exp);
		begin
			@(posedge clock);
			regSector <= sec;
			regOffset <= ofs;
			@(posedge clock);
			#1;
			chk(regRdata, exp);
		end
	endtask
	task idle;
		integer n;
		begin
			n = 0;
			while (busy !== 1'b0 && n < 20000) begin
				@(posedge clock);
				#1;
				n = n + 1;
			end
			if (n == 20000) begin
				err_count = err_count + 1;
				print_verdict;
			end
		end
	endtask
	task s_reset;
		begin
			rd(8'h00, 8'h00, 8'h00);
			rd(8'h00, 8'h01, 8'h00);
			rd(8'h01, 8'h40, 8'h00);
			rd(8'h00, 8'h40, 8'h00);
		end
	endtask
	task s_refuse;
		begin
			wr(8'h01, 8'h40, 8'h04);
			rd(8'h01, 8'h40, 8'h00);
			wr(8'h01, 8'h40, 8'hf1);
			rd(8'h01, 8'h40, 8'h00);
		end
	endtask
	task s_write;
		begin
			wr(8'h00, 8'h00, 8'hff);
			wr(8'h00, 8'h01, 8'hc3);
			globalIrqEnable <= 1'b0;
			wr(8'h01, 8'h40, 8'h08);
			wr(8'h01, 8'h40, 8'h0c);
			globalIrqEnable <= 1'b1;
			rd(8'h01, 8'h40, 8'h0c);
			// read permit first, then a read start that must be dropped while busy
			wr(8'h01, 8'h40, 8'h0a);
			wr(8'h01, 8'h40, 8'h0b);
			rd(8'h01, 8'h40, 8'h0e);
			idle;
			rd(8'h01, 8'h40, 8'h0a);
			chk(mfIrqFlag_q, 8'h01);
			chk(irqVector, 8'h01);
			@(posedge clock);
			stackFull <= 1'b1;
			@(posedge clock);
			#1;
			chk(irqVector, 8'h00);
			@(posedge clock);
			stackFull <= 1'b0;
			mfServiced <= 1'b1;
			@(posedge clock);
			mfServiced <= 1'b0;
			#1;
			chk(mfIrqFlag_q, 8'h00);
			chk(nvIrqFlag_q, 8'h01);
			@(posedge clock);
			nvIrqFlagClear <= 1'b1;
			@(posedge clock);
			nvIrqFlagClear <= 1'b0;
			#1;
			chk(nvIrqFlag_q, 8'h00);
		end
	endtask
	task s_read;
		begin
			wr(8'h00, 8'h01, 8'h00);
			wr(8'h01, 8'h40, 8'h02);
			wr(8'h01, 8'h40, 8'h03);
			#1;
			idle;
			rd(8'h00, 8'h01, 8'hc3);
			rd(8'h01, 8'h40, 8'h02);
			rd(8'h00, 8'h01, 8'hc3);
		end
	endtask
	// a strobe with the enable low must leave the address untouched
	task s_freeze;
		begin
			@(posedge clock);
			clockEnable <= 1'b0;
			wr(8'h00, 8'h00, 8'h55);
			clockEnable <= 1'b1;
			rd(8'h00, 8'h00, 8'hff);
		end
	endtask
	initial begin
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		s_reset;
		s_refuse;
		s_write;
		s_freeze;
		s_read;
		print_verdict;
	end
endmodule
bind data_eeprom_access_ctrl nv_ctrl_assertions chk_u (.*);
